// File: hw/emi_pkg.sv
// constants shared by the external memory port timing logic
package emi_pkg;
	// register addresses on the special function register port
	localparam logic [7:0] ADDR_TIMING = 8'haa;
	localparam logic [7:0] ADDR_CONFIG = 8'hb2;
	// reset values
	localparam logic [7:0] TIMING_RESET = 8'hff;
	localparam logic [4:0] CONFIG_RESET = 5'h03;
	localparam logic [2:0] CONFIG_UNUSED_READ = 3'h0;
	// field positions in the configuration register
	localparam int MUX_SELECT_BIT = 4;
	localparam int MAP_MODE_LSB = 2;
	localparam int LATCH_WIDTH_LSB = 0;
	// field positions in the timing register
	localparam int SETUP_LSB = 6;
	localparam int STROBE_LSB = 2;
	localparam int HOLD_LSB = 0;
	// memory map modes
	localparam logic [1:0] MAP_INTERNAL = 2'h0;
	localparam logic [1:0] MAP_SPLIT_NO_BANK = 2'h1;
	localparam logic [1:0] MAP_SPLIT_BANK = 2'h2;
	localparam logic [1:0] MAP_EXTERNAL = 2'h3;
	// first off-chip address of the split modes (4 kB)
	localparam logic [15:0] ONCHIP_LIMIT = 16'h1000;
	localparam int ONCHIP_ADDR_BITS = 12;
	typedef enum logic [2:0] {P_IDLE, P_ALE_HI, P_ALE_LO, P_SETUP, P_STROBE, P_HOLD} phase_t;
endpackage

// File: hw/phase_counter.sv
// down counter that times one phase of an off-chip access
`timescale 1ns/1ps
`default_nettype none
module phase_counter
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// load with cycles minus one
	input wire logic load,
	input wire logic [3:0] load_val,
	// remaining count
	output logic [3:0] count,
	output logic expired
);
	typedef struct packed
	{
		logic [3:0] cnt;
	} cnt_state_t;

	cnt_state_t st;
	cnt_state_t next_st;

	always_comb
	begin
		next_st = st;
		if (load)
			next_st.cnt = load_val;
		else if (st.cnt != 4'h0)
			next_st.cnt = st.cnt - 4'h1;
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign count = st.cnt;
	assign expired = (st.cnt == 4'h0);
endmodule
`default_nettype wire

// File: hw/ext_memory_interface_timing.sv
// external memory port: configuration registers, address routing and bus timing
`timescale 1ns/1ps
`default_nettype none
module ext_memory_interface_timing
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// external move request from the core
	input wire logic acc_req,
	input wire logic acc_write,
	input wire logic acc_8bit,
	input wire logic [15:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic [7:0] page_reg,
	input wire logic [7:0] addr_high_latch,
	output logic acc_busy,
	output logic acc_done,
	output logic [7:0] acc_rdata,
	// on-chip external data RAM select
	output logic onchip_sel,
	output logic [11:0] onchip_addr,
	// external memory pins
	output logic [7:0] ext_addr_hi,
	output logic [7:0] ext_addr_lo,
	input wire logic [7:0] ext_data_in,
	output logic [7:0] ext_data_out,
	output logic ext_data_oe,
	output logic ext_ale,
	output logic ext_rd_n,
	output logic ext_wr_n
);
	typedef struct packed
	{
		logic [4:0] cfg;
		logic [7:0] tim;
		logic [7:0] rdata;
		emi_pkg::phase_t phase;
		logic [7:0] lat_tim;
		logic [1:0] lat_lw;
		logic is_write;
		logic busy;
		logic done;
		logic [7:0] acc_rdata;
		logic onchip_sel;
		logic [11:0] onchip_addr;
		logic [7:0] addr_hi;
		logic [7:0] addr_lo;
		logic [7:0] data_out;
		logic [7:0] wdata;
		logic data_oe;
		logic ale;
		logic rd_n;
		logic wr_n;
		logic [7:0] sync1;
		logic [7:0] sync2;
	} emi_state_t;

	emi_state_t st;
	emi_state_t next_st;
	logic load;
	logic [3:0] load_val;
	logic expired;
	logic [15:0] eff_addr;
	logic offchip;
	logic mux_mode;
	logic [1:0] map_mode;

	phase_counter u_phase_counter
	(
		.clock(clock),
		.resetn(resetn),
		.load(load),
		.load_val(load_val),
		.count(),
		.expired(expired)
	);

	// -----------------------------------------------------------
	// routing of a new access
	// -----------------------------------------------------------
	assign mux_mode = ~st.cfg[emi_pkg::MUX_SELECT_BIT];
	assign map_mode = st.cfg[emi_pkg::MAP_MODE_LSB +: 2];

	always_comb
	begin
		eff_addr = acc_addr;
		if (acc_8bit)
		begin
			if (map_mode == emi_pkg::MAP_SPLIT_BANK)
				eff_addr[15:8] = page_reg;
			else
				eff_addr[15:8] = addr_high_latch;
		end
		case (map_mode)
			emi_pkg::MAP_INTERNAL: offchip = 1'b0;
			emi_pkg::MAP_EXTERNAL: offchip = 1'b1;
			default: offchip = (eff_addr >= emi_pkg::ONCHIP_LIMIT);
		endcase
	end

	// -----------------------------------------------------------
	// registers and access sequencer
	// -----------------------------------------------------------
	always_comb
	begin
		next_st = st;
		load = 1'b0;
		load_val = 4'h0;
		next_st.done = 1'b0;
		next_st.onchip_sel = 1'b0;
		next_st.sync1 = ext_data_in;
		next_st.sync2 = st.sync1;
		if (sfr_wr && sfr_addr == emi_pkg::ADDR_CONFIG)
			next_st.cfg = sfr_wdata[4:0];
		if (sfr_wr && sfr_addr == emi_pkg::ADDR_TIMING)
			next_st.tim = sfr_wdata;
		case (sfr_addr)
			emi_pkg::ADDR_CONFIG: next_st.rdata = {emi_pkg::CONFIG_UNUSED_READ, st.cfg};
			emi_pkg::ADDR_TIMING: next_st.rdata = st.tim;
			default: next_st.rdata = 8'h00;
		endcase
		case (st.phase)
			emi_pkg::P_IDLE:
			begin
				if (acc_req && !offchip)
				begin
					next_st.onchip_sel = 1'b1;
					next_st.onchip_addr = eff_addr[emi_pkg::ONCHIP_ADDR_BITS-1:0];
					next_st.done = 1'b1;
				end
				else if (acc_req)
				begin
					next_st.busy = 1'b1;
					next_st.is_write = acc_write;
					next_st.lat_tim = st.tim;
					next_st.lat_lw = st.cfg[emi_pkg::LATCH_WIDTH_LSB +: 2];
					next_st.addr_hi = eff_addr[15:8];
					next_st.data_out = acc_write ? acc_wdata : 8'h00;
					// the core holds write data for the request cycle only
					next_st.wdata = acc_wdata;
					if (mux_mode)
					begin
						// low address rides the data pins while the latch strobe is high
						next_st.phase = emi_pkg::P_ALE_HI;
						next_st.ale = 1'b1;
						next_st.addr_lo = 8'h00;
						next_st.data_out = eff_addr[7:0];
						next_st.data_oe = 1'b1;
						load = 1'b1;
						load_val = {2'b00, st.cfg[emi_pkg::LATCH_WIDTH_LSB +: 2]};
					end
					else
					begin
						next_st.addr_lo = eff_addr[7:0];
						next_st.data_oe = acc_write;
						next_st.phase = emi_pkg::P_SETUP;
						load = 1'b1;
						load_val = {2'b00, st.tim[emi_pkg::SETUP_LSB +: 2]};
						if (st.tim[emi_pkg::SETUP_LSB +: 2] == 2'h0)
						begin
							next_st.phase = emi_pkg::P_STROBE;
							load_val = st.tim[emi_pkg::STROBE_LSB +: 4];
							next_st.rd_n = acc_write;
							next_st.wr_n = ~acc_write;
						end
						else
							load_val = {2'b00, st.tim[emi_pkg::SETUP_LSB +: 2]} - 4'h1;
					end
				end
			end
			emi_pkg::P_ALE_HI:
			begin
				if (expired)
				begin
					next_st.phase = emi_pkg::P_ALE_LO;
					next_st.ale = 1'b0;
					load = 1'b1;
					load_val = {2'b00, st.lat_lw};
				end
			end
			emi_pkg::P_ALE_LO:
			begin
				if (expired)
				begin
					next_st.data_out = st.is_write ? st.wdata : 8'h00;
					next_st.data_oe = st.is_write;
					load = 1'b1;
					if (st.lat_tim[emi_pkg::SETUP_LSB +: 2] == 2'h0)
					begin
						next_st.phase = emi_pkg::P_STROBE;
						load_val = st.lat_tim[emi_pkg::STROBE_LSB +: 4];
						next_st.rd_n = st.is_write;
						next_st.wr_n = ~st.is_write;
					end
					else
					begin
						next_st.phase = emi_pkg::P_SETUP;
						load_val = {2'b00, st.lat_tim[emi_pkg::SETUP_LSB +: 2]} - 4'h1;
					end
				end
			end
			emi_pkg::P_SETUP:
			begin
				if (expired)
				begin
					next_st.phase = emi_pkg::P_STROBE;
					load = 1'b1;
					load_val = st.lat_tim[emi_pkg::STROBE_LSB +: 4];
					next_st.rd_n = st.is_write;
					next_st.wr_n = ~st.is_write;
				end
			end
			emi_pkg::P_STROBE:
			begin
				if (expired)
				begin
					next_st.rd_n = 1'b1;
					next_st.wr_n = 1'b1;
					if (!st.is_write)
						next_st.acc_rdata = st.sync2;
					if (st.lat_tim[emi_pkg::HOLD_LSB +: 2] == 2'h0)
					begin
						next_st.phase = emi_pkg::P_IDLE;
						next_st.busy = 1'b0;
						next_st.done = 1'b1;
						next_st.data_oe = 1'b0;
					end
					else
					begin
						next_st.phase = emi_pkg::P_HOLD;
						load = 1'b1;
						load_val = {2'b00, st.lat_tim[emi_pkg::HOLD_LSB +: 2]} - 4'h1;
					end
				end
			end
			emi_pkg::P_HOLD:
			begin
				if (expired)
				begin
					next_st.phase = emi_pkg::P_IDLE;
					next_st.busy = 1'b0;
					next_st.done = 1'b1;
					next_st.data_oe = 1'b0;
				end
			end
			default:
				next_st.phase = emi_pkg::P_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
			st.cfg <= emi_pkg::CONFIG_RESET;
			st.tim <= emi_pkg::TIMING_RESET;
			st.phase <= emi_pkg::P_IDLE;
			st.rd_n <= 1'b1;
			st.wr_n <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign sfr_rdata = st.rdata;
	assign acc_busy = st.busy;
	assign acc_done = st.done;
	assign acc_rdata = st.acc_rdata;
	assign onchip_sel = st.onchip_sel;
	assign onchip_addr = st.onchip_addr;
	assign ext_addr_hi = st.addr_hi;
	assign ext_addr_lo = st.addr_lo;
	assign ext_data_out = st.data_out;
	assign ext_data_oe = st.data_oe;
	assign ext_ale = st.ale;
	assign ext_rd_n = st.rd_n;
	assign ext_wr_n = st.wr_n;

	// -----------------------------------------------------------
	// checks
	// -----------------------------------------------------------
	emi_pkg::phase_t prev_phase;
	logic [4:0] run;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_phase <= emi_pkg::P_IDLE;
			run <= 5'h0;
		end
		else
		begin
			prev_phase <= st.phase;
			run <= (st.phase != prev_phase) ? 5'h1 : run + 5'h1;
		end
	end

	property p_mux_pins;
		@(posedge clock) disable iff (!resetn)
		ext_ale |-> (ext_data_oe && ext_addr_lo == 8'h00);
	endproperty
	a_mux_pins: assert property (p_mux_pins) else $error("latch phase without address on data pins");

	property p_internal_only;
		@(posedge clock) disable iff (!resetn)
		(acc_req && !acc_busy && map_mode == emi_pkg::MAP_INTERNAL)
			|=> (onchip_sel && onchip_addr == $past(acc_addr[11:0]) && !acc_busy);
	endproperty
	a_internal_only: assert property (p_internal_only) else $error("mode 00 access left chip");

	property p_split_low;
		@(posedge clock) disable iff (!resetn)
		(acc_req && !acc_busy && !acc_8bit && map_mode == emi_pkg::MAP_SPLIT_NO_BANK
			&& acc_addr < 16'h1000) |=> onchip_sel;
	endproperty
	a_split_low: assert property (p_split_low) else $error("low split address not on-chip");

	property p_bank_page;
		@(posedge clock) disable iff (!resetn)
		(acc_req && !acc_busy && acc_8bit && map_mode == emi_pkg::MAP_SPLIT_BANK
			&& page_reg >= 8'h10) |=> (acc_busy && ext_addr_hi == $past(page_reg));
	endproperty
	a_bank_page: assert property (p_bank_page) else $error("page register not used as high byte");

	property p_external_only;
		@(posedge clock) disable iff (!resetn)
		(acc_req && !acc_busy && map_mode == emi_pkg::MAP_EXTERNAL) |=> (!onchip_sel && acc_busy);
	endproperty
	a_external_only: assert property (p_external_only) else $error("mode 11 access went on-chip");

	property p_latch_width;
		@(posedge clock) disable iff (!resetn)
		(st.phase != prev_phase && (prev_phase == emi_pkg::P_ALE_HI || prev_phase == emi_pkg::P_ALE_LO))
			|-> run == {3'b000, st.lat_lw} + 5'h1;
	endproperty
	a_latch_width: assert property (p_latch_width) else $error("latch strobe phase length wrong");

	property p_no_latch_nonmux;
		@(posedge clock) disable iff (!resetn)
		(!acc_busy && acc_req && !mux_mode) |=> !ext_ale [*2];
	endproperty
	a_no_latch_nonmux: assert property (p_no_latch_nonmux) else $error("latch strobe in separate-bus mode");

	property p_setup_len;
		@(posedge clock) disable iff (!resetn)
		(st.phase != prev_phase && prev_phase == emi_pkg::P_SETUP)
			|-> run == {3'b000, st.lat_tim[7:6]};
	endproperty
	a_setup_len: assert property (p_setup_len) else $error("setup phase length wrong");

	property p_strobe_len;
		@(posedge clock) disable iff (!resetn)
		$rose(ext_rd_n && ext_wr_n) |-> run == {1'b0, st.lat_tim[5:2]} + 5'h1;
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("read or write strobe length wrong");

	property p_hold_len;
		@(posedge clock) disable iff (!resetn)
		(st.phase != prev_phase && prev_phase == emi_pkg::P_HOLD)
			|-> (run == {3'b000, st.lat_tim[1:0]} && acc_done);
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold phase length wrong");

	property p_upper_zero;
		@(posedge clock) disable iff (!resetn)
		(sfr_addr == emi_pkg::ADDR_CONFIG) |=> sfr_rdata[7:5] == 3'b000;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("unused config bits read nonzero");

	property p_order;
		@(posedge clock) disable iff (!resetn)
		(st.phase == emi_pkg::P_STROBE && prev_phase != emi_pkg::P_STROBE)
			|-> (prev_phase == emi_pkg::P_SETUP || prev_phase == emi_pkg::P_ALE_LO
			|| prev_phase == emi_pkg::P_IDLE);
	endproperty
	a_order: assert property (p_order) else $error("strobe entered out of sequence");
endmodule
`default_nettype wire

// File: sim/ext_memory_model.sv
// behavioural external parallel memory on the port pins
`timescale 1ns/1ps
`default_nettype none
module ext_memory_model
(
	// clock and bus mode from the bench
	input wire logic clock,
	input wire logic muxed,
	// memory pins
	input wire logic [7:0] addr_hi,
	input wire logic [7:0] addr_lo,
	input wire logic [7:0] data_out,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	output logic [7:0] data_in,
	// address seen at the last strobe
	output logic [15:0] last_addr
);
	// ----------------------------------------
	// storage and address latch
	// ----------------------------------------
	logic [7:0] mem [0:65535];
	logic [7:0] lat_lo;
	logic [7:0] last_rd;
	logic [15:0] addr;
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
		lat_lo = 8'h00;
		last_rd = 8'h00;
		last_addr = 16'h0000;
	end
	assign addr = {addr_hi, muxed ? lat_lo : addr_lo};
	// released bus shows the inverse of the last driven byte
	assign data_in = !rd_n ? mem[addr] : ~last_rd;
	always @(posedge clock)
	begin
		if (ale)
			lat_lo <= data_out;
		if (!rd_n)
			last_rd <= mem[addr];
		if (!wr_n)
			mem[addr] <= data_out;
		if (!(rd_n & wr_n))
			last_addr <= addr;
	end
endmodule
`default_nettype wire

// File: sim/test_ext_memory_interface_timing.sv
// self-checking bench for the external memory port timing block
`timescale 1ns/1ps
`default_nettype none
module test_ext_memory_interface_timing;
	logic clock, resetn, sfr_wr, acc_req, acc_write, acc_8bit, muxed, saw_onchip;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, acc_wdata, page_reg, addr_high_latch;
	logic [7:0] acc_rdata, ext_addr_hi, ext_addr_lo, ext_data_in, ext_data_out;
	logic [15:0] acc_addr, last_addr;
	logic [11:0] onchip_addr, on_addr;
	logic acc_busy, acc_done, onchip_sel, ext_data_oe, ext_ale, ext_rd_n, ext_wr_n;
	int bad_count, tests_run, n_done, n_ale, n_first, n_strobe, n_busy, n_oe;
	ext_memory_interface_timing uut (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .acc_req(acc_req),
		.acc_write(acc_write), .acc_8bit(acc_8bit), .acc_addr(acc_addr),
		.acc_wdata(acc_wdata), .page_reg(page_reg), .addr_high_latch(addr_high_latch),
		.acc_busy(acc_busy), .acc_done(acc_done), .acc_rdata(acc_rdata),
		.onchip_sel(onchip_sel), .onchip_addr(onchip_addr), .ext_addr_hi(ext_addr_hi),
		.ext_addr_lo(ext_addr_lo), .ext_data_in(ext_data_in), .ext_data_out(ext_data_out),
		.ext_data_oe(ext_data_oe), .ext_ale(ext_ale), .ext_rd_n(ext_rd_n),
		.ext_wr_n(ext_wr_n));
	ext_memory_model mdl (.clock(clock), .muxed(muxed), .addr_hi(ext_addr_hi),
		.addr_lo(ext_addr_lo), .data_out(ext_data_out), .ale(ext_ale), .rd_n(ext_rd_n),
		.wr_n(ext_wr_n), .data_in(ext_data_in), .last_addr(last_addr));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clock);
		sfr_wr <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr <= a;
		repeat (2) @(posedge clock);
		#1;
		check(sfr_rdata, exp);
		@(posedge clock);
	endtask
	task automatic set_cfg(input logic mx, input logic [1:0] mode, input logic [1:0] lw);
		muxed <= ~mx;
		wr(emi_pkg::ADDR_CONFIG, {3'h0, mx, mode, lw});
	endtask
	// one access; counts cycles from the taking edge to done
	task automatic access(input logic w, input logic b8, input logic [15:0] a,
		input logic [7:0] d);
		acc_write <= w;
		acc_8bit <= b8;
		acc_addr <= a;
		acc_wdata <= d;
		acc_req <= 1'b1;
		@(posedge clock);
		acc_req <= 1'b0;
		n_done = 0;
		n_ale = 0;
		n_first = 0;
		n_strobe = 0;
		n_busy = 0;
		n_oe = 0;
		saw_onchip = 1'b0;
		// sample i shows what the design launched at the (i-1)th edge after the taking edge
		for (int i = 1; i < 80 && n_done == 0; i++)
		begin
			#1;
			if (ext_ale === 1'b1)
				n_ale++;
			if (acc_busy === 1'b1)
				n_busy++;
			if ((ext_rd_n & ext_wr_n) === 1'b0 && ext_data_oe === w)
				n_oe++;
			if ((ext_rd_n & ext_wr_n) === 1'b0)
			begin
				n_strobe++;
				if (n_first == 0)
					n_first = i;
			end
			if (onchip_sel === 1'b1)
			begin
				saw_onchip = 1'b1;
				on_addr = onchip_addr;
			end
			if (acc_done === 1'b1)
				n_done = i;
			@(posedge clock);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rd(emi_pkg::ADDR_TIMING, emi_pkg::TIMING_RESET);
		rd(emi_pkg::ADDR_CONFIG, 8'h03);
		wr(emi_pkg::ADDR_CONFIG, 8'hff);
		rd(emi_pkg::ADDR_CONFIG, 8'h1f);
		wr(emi_pkg::ADDR_TIMING, 8'h5a);
		rd(emi_pkg::ADDR_TIMING, 8'h5a);
		rd(8'h00, 8'h00);
	endtask
	task automatic t_route();
		wr(emi_pkg::ADDR_TIMING, 8'h0c);
		set_cfg(1'b1, emi_pkg::MAP_INTERNAL, 2'h0);
		access(1'b0, 1'b0, 16'h3456, 8'h00);
		check(saw_onchip, 1'b1);
		check(on_addr, 12'h456);
		check(n_strobe, 0);
		check(n_busy, 0);
		set_cfg(1'b1, emi_pkg::MAP_EXTERNAL, 2'h0);
		access(1'b0, 1'b0, 16'h0010, 8'h00);
		check(saw_onchip, 1'b0);
		check(last_addr, 16'h0010);
		check(acc_rdata, 8'h4a);
		set_cfg(1'b1, emi_pkg::MAP_SPLIT_NO_BANK, 2'h0);
		addr_high_latch <= 8'h23;
		page_reg <= 8'h71;
		access(1'b0, 1'b0, 16'h0fff, 8'h00);
		check(saw_onchip, 1'b1);
		access(1'b0, 1'b0, 16'h1000, 8'h00);
		check(saw_onchip, 1'b0);
		check(last_addr, 16'h1000);
		access(1'b0, 1'b1, 16'h5545, 8'h00);
		check(last_addr, 16'h2345);
		check(acc_rdata, 8'h3c);
		set_cfg(1'b1, emi_pkg::MAP_SPLIT_BANK, 2'h0);
		access(1'b0, 1'b1, 16'h3399, 8'h00);
		check(last_addr, 16'h7199);
		check(acc_rdata, 8'hb2);
	endtask
	task automatic t_reset();
		resetn <= 1'b0;
		@(posedge clock);
		resetn <= 1'b1;
		rd(emi_pkg::ADDR_CONFIG, 8'h03);
		rd(emi_pkg::ADDR_TIMING, emi_pkg::TIMING_RESET);
		access(1'b0, 1'b0, 16'h1234, 8'h00);
		check(saw_onchip, 1'b1);
		check(on_addr, 12'h234);
	endtask
	task automatic t_timing();
		logic [10:0] tbl [6] = '{11'h700, 11'h045, 11'h3ff, 11'h48e, 11'h108, 11'h2c1};
		int pre;
		logic [15:0] a;
		for (int k = 0; k < 6; k++)
		begin
			a = 16'h4000 + 16'(k);
			set_cfg(tbl[k][10], emi_pkg::MAP_EXTERNAL, tbl[k][9:8]);
			wr(emi_pkg::ADDR_TIMING, tbl[k][7:0]);
			pre = tbl[k][10] ? 0 : 2 * (tbl[k][9:8] + 1);
			access(1'b1, 1'b0, a, 8'hc3 ^ 8'(k));
			check(n_done, pre + tbl[k][7:6] + tbl[k][5:2] + tbl[k][1:0] + 2);
			check(n_busy, pre + tbl[k][7:6] + tbl[k][5:2] + tbl[k][1:0] + 1);
			check(n_oe, tbl[k][5:2] + 1);
			check(n_ale, tbl[k][10] ? 0 : tbl[k][9:8] + 1);
			check(n_first, pre + tbl[k][7:6] + 1);
			check(n_strobe, tbl[k][5:2] + 1);
			check(last_addr, a);
			access(1'b0, 1'b0, a, 8'h00);
			check(n_first, pre + tbl[k][7:6] + 1);
			check(n_oe, tbl[k][5:2] + 1);
			// read data passes two sync flops, so strobes under three cycles return stale data
			if (tbl[k][5:2] > 4'h1)
				check(acc_rdata, 8'hc3 ^ 8'(k));
		end
	endtask
	// ----------------------------------------
	// clock, reset, sequence and watchdog
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		{resetn, sfr_wr, acc_req, acc_write, acc_8bit, muxed} = 6'h02;
		{sfr_addr, sfr_wdata, acc_wdata, page_reg, addr_high_latch} = 40'h0;
		acc_addr = 16'h0000;
		bad_count = 0;
		tests_run = 0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		t_regs();
		t_route();
		t_timing();
		t_reset();
		final_report();
	end
	initial
	begin
		repeat (5000) @(posedge clock);
		bad_count++;
		final_report();
	end
endmodule
`default_nettype wire
